// *** hw/pcimt_defs.vh ***
// Constants shared by the PCI initiator and target interface files.
`ifndef PCIMT_DEFS_VH
`define PCIMT_DEFS_VH

// Bus command codes carried on the command/byte-enable lines.
`define PCIMT_CMD_SPECIAL 4'h1
`define PCIMT_CMD_IO_RD   4'h2
`define PCIMT_CMD_IO_WR   4'h3
`define PCIMT_CMD_MEM_RD  4'h6
`define PCIMT_CMD_MEM_WR  4'h7
`define PCIMT_CMD_CFG_RD  4'hA
`define PCIMT_CMD_CFG_WR  4'hB

// Command bit that is set for every write command.
`define PCIMT_CMD_WR_BIT  0

// Address field that selects a type 0 configuration access.
`define PCIMT_AD_TYPE     1:0
`define PCIMT_CFG_TYPE0   2'h0

// Mask that turns a byte address into a doubleword address.
`define PCIMT_DW_MASK     32'hFFFFFFFC
`define PCIMT_ZERO32      32'h00000000

// Data clocks without a device select before the initiator gives up.
`define PCIMT_DEVSEL_TMO  3'h4
`define PCIMT_CNT_ONE     3'h1
`define PCIMT_CNT_ZERO    3'h0

// Completion status reported to the initiator user side.
`define PCIMT_ST_OK       2'h0
`define PCIMT_ST_RETRY    2'h1
`define PCIMT_ST_MABORT   2'h2
`define PCIMT_ST_TABORT   2'h3

`endif

// *** hw/pcimt_par.v ***
// Even parity generator over the address/data and command lines.
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////////
// The parity bit makes the 37 lines together carry an even count of ones.
module pcimt_par (
  input  wire [31:0] ad,
  input  wire [3:0]  cbe_n,
  output wire        par
);

  // Reduction over all 36 data and command lines.
  assign par = ^{ad, cbe_n};

endmodule // pcimt_par

// *** hw/pcimt_err.v ***
// System error and data parity error drivers for the PCI interface.
`timescale 1ns/1ps
`include "pcimt_defs.vh"

////////////////////////////////////////////////////////////////////////////////
// Turns address and data parity faults into the two error pin drives.
module pcimt_err (
  input  wire clk,
  input  wire rst_b,
  input  wire addr_bad,
  input  wire data_bad,
  output reg  serr_oe,
  output reg  perr_n_o,
  output reg  perr_oe
);

  ////////////////////////////////////////////////////////////////////////////////
  // The system error pin is pulled low for one clock per bad address.
  // The parity error pin goes low for each bad data phase, is then
  // driven high for one clock, and only then is released.
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      serr_oe  <= 1'b0;
      perr_n_o <= 1'b1;
      perr_oe  <= 1'b0;
    end else begin
      // One clock of low drive on the open-drain system error line.
      serr_oe <= addr_bad;
      if (data_bad) begin
        // Low for at least one clock for this data phase.
        perr_n_o <= 1'b0;
        perr_oe  <= 1'b1;
      end else if (perr_oe && !perr_n_o) begin
        // Drive high for a clock before letting go of the line.
        perr_n_o <= 1'b1;
      end else begin
        // Release the sustained line.
        perr_oe <= 1'b0;
      end
    end
  end

endmodule // pcimt_err

// *** hw/pcimt_top.v ***
// PCI initiator and target bus interface for the network controller.
`timescale 1ns/1ps
`include "pcimt_defs.vh"

////////////////////////////////////////////////////////////////////////////////
module pcimt_top (
  input  wire        clk,
  input  wire        rst_b,
  input  wire [31:0] ad_i,
  output reg  [31:0] ad_o,
  output reg         ad_oe,
  input  wire [3:0]  cbe_n_i,
  output reg  [3:0]  cbe_n_o,
  output reg         cbe_oe,
  input  wire        par_i,
  output reg         par_o,
  output reg         par_oe,
  input  wire        frame_n_i,
  output reg         frame_n_o,
  output reg         frame_oe,
  input  wire        irdy_n_i,
  output reg         irdy_n_o,
  output reg         irdy_oe,
  input  wire        trdy_n_i,
  output reg         trdy_n_o,
  output reg         trdy_oe,
  input  wire        stop_n_i,
  output reg         stop_n_o,
  output reg         stop_oe,
  input  wire        devsel_n_i,
  output reg         devsel_n_o,
  output reg         devsel_oe,
  input  wire        idsel_i,
  output reg         req_n_o,
  output reg         req_oe,
  input  wire        gnt_n_i,
  output reg         inta_n_o,
  output reg         inta_oe,
  output wire        serr_oe,
  output wire        perr_n_o,
  output wire        perr_oe,
  input  wire        mst_start,
  input  wire [3:0]  mst_cmd,
  input  wire [31:0] mst_addr,
  input  wire [31:0] mst_wdata,
  input  wire [3:0]  mst_be_n,
  output reg         mst_busy,
  output reg         mst_done,
  output reg  [1:0]  mst_status,
  output reg  [31:0] mst_rdata,
  input  wire [31:0] tgt_mem_base,
  input  wire [31:0] tgt_mem_mask,
  input  wire [31:0] tgt_io_base,
  input  wire [31:0] tgt_io_mask,
  output reg         tgt_req,
  output reg  [3:0]  tgt_cmd,
  output reg  [31:0] tgt_addr,
  input  wire [31:0] tgt_rdata,
  output reg         tgt_wr,
  output reg  [31:0] tgt_wdata,
  output reg  [3:0]  tgt_be_n,
  input  wire        irq
);

  // Initiator states, one-hot; each names what the bus shows this cycle.
  localparam M_IDLE = 4'h1;
  localparam M_ADDR = 4'h2;
  localparam M_DATA = 4'h4;
  localparam M_TURN = 4'h8;

  // Target states, one-hot.
  localparam T_IDLE = 5'h01;
  localparam T_WAIT = 5'h02;
  localparam T_DATA = 5'h04;
  localparam T_HOLD = 5'h08;
  localparam T_TURN = 5'h10;

  reg  [3:0]  m_state;   // Initiator sequencer.
  reg  [4:0]  t_state;   // Target sequencer.
  reg  [3:0]  m_cmd;     // Latched initiator command.
  reg  [31:0] m_addr;    // Latched initiator address.
  reg  [31:0] m_wdata;   // Latched initiator write data.
  reg  [3:0]  m_be_n;    // Latched initiator byte enables.
  reg  [2:0]  dsel_cnt;  // Data clocks spent without a claim.
  reg         frame_q;   // Frame level seen on the previous clock.
  reg         t_write;   // Claimed access is a write.
  reg         rx_par_q;  // Parity of lines sampled on the previous clock.
  reg         chk_addr;  // Previous clock held a foreign address phase.
  reg         chk_data;  // Previous clock completed a data phase we received.
  wire        rx_par;    // Parity of the lines as sampled now.
  wire        tx_par;    // Parity of the lines as we drive them now.
  wire        addr_bad;  // Address parity fault found this clock.
  wire        data_bad;  // Data parity fault found this clock.

  ////////////////////////////////////////////////////////////////////////////////
  // Address phase decode for the target side.

  // A foreign address phase is the first clock of frame low not driven by us.
  wire addr_ph  = !frame_n_i && frame_q && !frame_oe;
  wire cmd_mem  = (cbe_n_i == `PCIMT_CMD_MEM_RD) || (cbe_n_i == `PCIMT_CMD_MEM_WR);
  wire cmd_io   = (cbe_n_i == `PCIMT_CMD_IO_RD) || (cbe_n_i == `PCIMT_CMD_IO_WR);
  wire cmd_cfg  = (cbe_n_i == `PCIMT_CMD_CFG_RD) || (cbe_n_i == `PCIMT_CMD_CFG_WR);
  // Memory windows match doublewords, I/O windows match bytes.
  wire mem_hit  = cmd_mem &&
                  ((((ad_i ^ tgt_mem_base) & tgt_mem_mask) & `PCIMT_DW_MASK)
                   == `PCIMT_ZERO32);
  wire io_hit   = cmd_io &&
                  (((ad_i ^ tgt_io_base) & tgt_io_mask) == `PCIMT_ZERO32);
  // Configuration is claimed only while the select input is high.
  wire cfg_hit  = cmd_cfg && idsel_i &&
                  (ad_i[`PCIMT_AD_TYPE] == `PCIMT_CFG_TYPE0);
  wire t_hit    = addr_ph && (mem_hit || io_hit || cfg_hit);
  // The initiator may start only when granted and the bus is idle.
  wire m_go     = mst_busy && !gnt_n_i && frame_n_i && irdy_n_i &&
                  (t_state == T_IDLE);
  // The initiator phase ends on completion, stop, or no claim in time.
  wire m_end    = !trdy_n_i || !stop_n_i ||
                  (devsel_n_i && (dsel_cnt == `PCIMT_DEVSEL_TMO));

  ////////////////////////////////////////////////////////////////////////////////
  // Parity on the driven lines and on the received lines.

  pcimt_par u_tx_par (
    .ad    (ad_o),
    .cbe_n (cbe_oe ? cbe_n_o : cbe_n_i),
    .par   (tx_par)
  );

  pcimt_par u_rx_par (
    .ad    (ad_i),
    .cbe_n (cbe_n_i),
    .par   (rx_par)
  );

  // The parity line lags its data by a clock; compare with the stored sum.
  assign addr_bad = chk_addr && (rx_par_q != par_i);
  assign data_bad = chk_data && (rx_par_q != par_i);

  pcimt_err u_err (
    .clk      (clk),
    .rst_b    (rst_b),
    .addr_bad (addr_bad),
    .data_bad (data_bad),
    .serr_oe  (serr_oe),
    .perr_n_o (perr_n_o),
    .perr_oe  (perr_oe)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Pin drivers, initiator sequencer and target sequencer.
  // Both sequencers share the address/data drivers; they never run together
  // because the initiator starts only while the target sits idle and the
  // target never claims an address phase that we drive.
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      // Every pin floats and both sequencers return to idle.
      ad_o       <= `PCIMT_ZERO32;
      ad_oe      <= 1'b0;
      cbe_n_o    <= 4'hF;
      cbe_oe     <= 1'b0;
      par_o      <= 1'b0;
      par_oe     <= 1'b0;
      frame_n_o  <= 1'b1;
      frame_oe   <= 1'b0;
      irdy_n_o   <= 1'b1;
      irdy_oe    <= 1'b0;
      trdy_n_o   <= 1'b1;
      trdy_oe    <= 1'b0;
      stop_n_o   <= 1'b1;
      stop_oe    <= 1'b0;
      devsel_n_o <= 1'b1;
      devsel_oe  <= 1'b0;
      req_n_o    <= 1'b1;
      req_oe     <= 1'b0;
      inta_n_o   <= 1'b0;
      inta_oe    <= 1'b0;
      m_state    <= M_IDLE;
      t_state    <= T_IDLE;
      m_cmd      <= 4'h0;
      m_addr     <= `PCIMT_ZERO32;
      m_wdata    <= `PCIMT_ZERO32;
      m_be_n     <= 4'hF;
      dsel_cnt   <= `PCIMT_CNT_ZERO;
      frame_q    <= 1'b1;
      t_write    <= 1'b0;
      rx_par_q   <= 1'b0;
      chk_addr   <= 1'b0;
      chk_data   <= 1'b0;
      mst_busy   <= 1'b0;
      mst_done   <= 1'b0;
      mst_status <= `PCIMT_ST_OK;
      mst_rdata  <= `PCIMT_ZERO32;
      tgt_req    <= 1'b0;
      tgt_cmd    <= 4'h0;
      tgt_addr   <= `PCIMT_ZERO32;
      tgt_wr     <= 1'b0;
      tgt_wdata  <= `PCIMT_ZERO32;
      tgt_be_n   <= 4'hF;
    end else begin
      mst_done <= 1'b0;
      tgt_req  <= 1'b0;
      tgt_wr   <= 1'b0;
      frame_q  <= frame_n_i;
      rx_par_q <= rx_par;
      req_oe   <= 1'b1;
      inta_n_o <= 1'b0;
      // Interrupt line is pulled low for as long as the source is high.
      inta_oe  <= irq;
      // Parity trails whatever we drove on the data lines by one clock,
      // so it covers addresses, write data and target read data alike.
      par_o    <= tx_par;
      par_oe   <= ad_oe;
      // Foreign address phases are always checked for parity.
      chk_addr <= addr_ph;
      // Data is checked only after a claim and a completed phase we received.
      chk_data <= ((t_state == T_DATA) && !irdy_n_i && t_write) ||
                  ((m_state == M_DATA) && !trdy_n_i &&
                   !m_cmd[`PCIMT_CMD_WR_BIT]);
      // Accept a new initiator job only while none is pending.
      if (mst_start && !mst_busy) begin
        mst_busy <= 1'b1;
        m_cmd    <= mst_cmd;
        m_addr   <= mst_addr;
        m_wdata  <= mst_wdata;
        m_be_n   <= mst_be_n;
      end

      // Initiator sequencer: one address phase and one data phase.
      case (m_state)
        M_IDLE: begin
          if (m_go) begin
            // Frame low with address and command on the bus.
            m_state   <= M_ADDR;
            frame_n_o <= 1'b0;
            frame_oe  <= 1'b1;
            irdy_n_o  <= 1'b1;
            irdy_oe   <= 1'b1;
            ad_o      <= m_addr;
            ad_oe     <= 1'b1;
            cbe_n_o   <= m_cmd;
            cbe_oe    <= 1'b1;
            dsel_cnt  <= `PCIMT_CNT_ZERO;
            req_n_o   <= 1'b1;
          end else begin
            // Request is held while a job waits for the grant.
            req_n_o <= !mst_busy;
          end
        end
        M_ADDR: begin
          // Single data phase, so frame rises as the ready falls.
          m_state   <= M_DATA;
          frame_n_o <= 1'b1;
          irdy_n_o  <= 1'b0;
          cbe_n_o   <= m_be_n;
          ad_o      <= m_wdata;
          ad_oe     <= m_cmd[`PCIMT_CMD_WR_BIT];
        end
        M_DATA: begin
          if (devsel_n_i) begin
            dsel_cnt <= dsel_cnt + `PCIMT_CNT_ONE;
          end
          if (m_end) begin
            // Ready goes high for a clock; frame was high a clock already.
            m_state   <= M_TURN;
            irdy_n_o  <= 1'b1;
            frame_oe  <= 1'b0;
            ad_oe     <= 1'b0;
            cbe_oe    <= 1'b0;
            mst_done  <= 1'b1;
            mst_busy  <= 1'b0;
            mst_rdata <= ad_i;
            if (!trdy_n_i) begin
              mst_status <= `PCIMT_ST_OK;
            end else if (!stop_n_i && devsel_n_i) begin
              mst_status <= `PCIMT_ST_TABORT;
            end else if (!stop_n_i) begin
              mst_status <= `PCIMT_ST_RETRY;
            end else begin
              mst_status <= `PCIMT_ST_MABORT;
            end
          end
        end
        M_TURN: begin
          // Release the ready line after its high clock.
          m_state <= M_IDLE;
          irdy_oe <= 1'b0;
        end
        default: begin
          m_state <= M_IDLE;
        end
      endcase

      // Target sequencer: claim, one data phase, then disconnect.
      case (t_state)
        T_IDLE: begin
          if (t_hit) begin
            // Claim the access the clock after the address.
            t_state    <= T_WAIT;
            devsel_n_o <= 1'b0;
            devsel_oe  <= 1'b1;
            trdy_n_o   <= 1'b1;
            trdy_oe    <= 1'b1;
            stop_n_o   <= 1'b1;
            stop_oe    <= 1'b1;
            tgt_req    <= 1'b1;
            tgt_cmd    <= cbe_n_i;
            tgt_addr   <= cmd_io ? ad_i : (ad_i & `PCIMT_DW_MASK);
            t_write    <= cbe_n_i[`PCIMT_CMD_WR_BIT];
          end
        end
        T_WAIT: begin
          // Ready with read data after the turnaround clock; stop when
          // the initiator still wants more phases.
          t_state  <= T_DATA;
          trdy_n_o <= 1'b0;
          stop_n_o <= frame_n_i;
          ad_o     <= tgt_rdata;
          ad_oe    <= !t_write;
        end
        T_DATA: begin
          if (!irdy_n_i) begin
            // Phase complete: hand the write to the user side.
            trdy_n_o  <= 1'b1;
            ad_oe     <= 1'b0;
            tgt_wr    <= t_write;
            tgt_wdata <= ad_i;
            tgt_be_n  <= cbe_n_i;
            if (frame_n_i) begin
              t_state    <= T_TURN;
              devsel_n_o <= 1'b1;
              stop_n_o   <= 1'b1;
            end else begin
              t_state <= T_HOLD;
            end
          end
        end
        T_HOLD: begin
          // Keep stop low until the initiator lets frame rise.
          if (frame_n_i) begin
            t_state    <= T_TURN;
            devsel_n_o <= 1'b1;
            stop_n_o   <= 1'b1;
          end
        end
        T_TURN: begin
          // Release the control lines after their high clock.
          t_state   <= T_IDLE;
          devsel_oe <= 1'b0;
          trdy_oe   <= 1'b0;
          stop_oe   <= 1'b0;
        end
        default: begin
          t_state <= T_IDLE;
        end
      endcase
    end
  end

endmodule // pcimt_top

// *** verif/pcimt_monitor.sv ***
// Checker of the PCI pin behaviour seen at the interface block's ports.
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////////
// Watches the block's pin drives against the bus lines that it samples.
module pcimt_monitor (
  input wire        clk,
  input wire        rst_b,
  input wire [31:0] ad_o,
  input wire        ad_oe,
  input wire [3:0]  cbe_n_o,
  input wire        cbe_oe,
  input wire        par_o,
  input wire        par_oe,
  input wire        frame_n_o,
  input wire        frame_oe,
  input wire        irdy_n_i,
  input wire        irdy_n_o,
  input wire        irdy_oe,
  input wire        trdy_n_i,
  input wire        devsel_n_o,
  input wire        devsel_oe,
  input wire        gnt_n_i,
  input wire        inta_n_o,
  input wire        inta_oe,
  input wire        serr_oe,
  input wire        perr_n_o,
  input wire        perr_oe,
  input wire        irq
);
  wire cpl = !irdy_n_i && !trdy_n_i;  // A data phase completes at this edge.

  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);

  // Parity on the pin covers the lines driven one clock earlier.
  property p_par_even;
    par_oe && $past(cbe_oe) |-> par_o == ^{$past(ad_o), $past(cbe_n_o)};
  endproperty
  a_par_even: assert property (p_par_even) else $error("parity bit wrong");
  property p_par_hold; $fell(ad_oe) |-> par_oe ##1 !par_oe; endproperty
  a_par_hold: assert property (p_par_hold) else $error("parity not held");
  property p_frame_last; frame_oe && !frame_n_o |=> frame_n_o && !irdy_n_o && irdy_oe; endproperty
  a_frame_last: assert property (p_frame_last) else $error("frame end wrong");
  property p_gnt; $fell(frame_n_o) |-> $past(gnt_n_i) == 1'b0; endproperty
  a_gnt: assert property (p_gnt) else $error("start without grant");
  property p_serr; serr_oe |=> !serr_oe; endproperty
  a_serr: assert property (p_serr) else $error("system error too long");
  property p_perr_cause; perr_oe && !perr_n_o |-> $past(cpl, 2) || $past(cpl, 3); endproperty
  a_perr_cause: assert property (p_perr_cause) else $error("parity error untimely");
  property p_perr_end; perr_oe && !perr_n_o |=> perr_oe && perr_n_o ##1 !perr_oe; endproperty
  a_perr_end: assert property (p_perr_end) else $error("parity error release");
  property p_dsel_end; devsel_oe && $rose(devsel_n_o) |=> !devsel_oe; endproperty
  a_dsel_end: assert property (p_dsel_end) else $error("select not floated");
  property p_inta; irq |=> inta_oe && !inta_n_o; endproperty
  a_inta: assert property (p_inta) else $error("interrupt not low");
  property p_rst_float;
    disable iff (1'b0) !rst_b |-> !(ad_oe | cbe_oe | par_oe | frame_oe | devsel_oe | perr_oe);
  endproperty
  a_rst_float: assert property (p_rst_float) else $error("driving in reset");
endmodule // pcimt_monitor

bind pcimt_top pcimt_monitor i_mon (
  .clk, .rst_b, .ad_o, .ad_oe, .cbe_n_o, .cbe_oe, .par_o, .par_oe, .frame_n_o, .frame_oe,
  .irdy_n_i, .irdy_n_o, .irdy_oe, .trdy_n_i, .devsel_n_o, .devsel_oe, .gnt_n_i, .inta_n_o,
  .inta_oe, .serr_oe, .perr_n_o, .perr_oe, .irq
);

// *** verif/pcimt_host_model.sv ***
// Arbiter and plain target standing on the far side of the block's initiator.
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////////
// Grants every request and answers one data phase per transaction.
module pcimt_host_model (
  input  wire        clk,
  input  wire        rst_b,
  input  wire [1:0]  mode,      // Answer: 0 accept, 1 never claim, 2 retry.
  input  wire [31:0] rdata,     // Data returned on reads.
  input  wire        req_n,
  input  wire        frame_n,
  input  wire        irdy_n,
  input  wire [31:0] ad,
  input  wire [3:0]  cbe_n,
  output reg         gnt_n,
  output reg         ctl_oe,    // Drives select, ready and stop while high.
  output reg         devsel_n,
  output reg         trdy_n,
  output reg         stop_n,
  output reg         ad_oe,
  output reg         par_oe,
  output reg         par,
  output reg  [31:0] cap_addr,
  output reg  [3:0]  cap_cmd,
  output reg  [31:0] cap_data,
  output reg  [3:0]  cap_be_n
);
  reg frame_q;  // Frame one clock ago, to find the address phase.
  reg act;      // A claimed transaction is open.

  // Claims, completes, then drives the controls high one clock before floating.
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      gnt_n    <= 1'b1;
      frame_q  <= 1'b1;
      act      <= 1'b0;
      ctl_oe   <= 1'b0;
      devsel_n <= 1'b1;
      trdy_n   <= 1'b1;
      stop_n   <= 1'b1;
      ad_oe    <= 1'b0;
      par_oe   <= 1'b0;
      par      <= 1'b0;
    end else begin
      gnt_n   <= req_n;
      frame_q <= frame_n;
      par_oe  <= ad_oe;
      par     <= ^{rdata, cbe_n};
      if (!act && !frame_n && frame_q && mode != 2'h1) begin
        act      <= 1'b1;
        ctl_oe   <= 1'b1;
        devsel_n <= 1'b0;
        trdy_n   <= (mode == 2'h2);
        stop_n   <= (mode != 2'h2);
        ad_oe    <= !cbe_n[0];
        cap_addr <= ad;
        cap_cmd  <= cbe_n;
      end else if (act && !irdy_n && !(trdy_n && stop_n)) begin
        act      <= 1'b0;
        devsel_n <= 1'b1;
        trdy_n   <= 1'b1;
        stop_n   <= 1'b1;
        ad_oe    <= 1'b0;
        cap_data <= ad;
        cap_be_n <= cbe_n;
      end else if (!act) begin
        ctl_oe <= 1'b0;
      end
    end
  end
endmodule // pcimt_host_model

// *** verif/tb.sv ***
// Self-checking bench for the PCI initiator and target interface.
`timescale 1ns/1ps

module tb;
  reg         clk = 1'b0, rst_b = 1'b1, mst_start = 1'b0, irq = 1'b0, idsel = 1'b0;
  reg  [3:0]  mst_cmd = 4'h0, t_cbe = 4'hF;
  reg  [1:0]  h_mode = 2'h1;
  reg         t_oe = 1'b0, t_frame = 1'b1, t_irdy = 1'b1, t_adoe = 1'b0;
  reg         t_paroe = 1'b0, t_par = 1'b0, par_last = 1'b0, got_claim;
  reg  [31:0] t_ad = 32'h0, ad_last = 32'h0, wd_seen = 32'h0, rdv;
  reg  [3:0]  cbe_last = 4'h0;
  integer     failures = 0, checks = 0, serr_cnt = 0, perr_cnt = 0;
  wire [31:0] ad_o, mst_rdata, tgt_addr, tgt_wdata, cap_addr, cap_data;
  wire [3:0]  cbe_n_o, tgt_cmd, tgt_be_n, cap_cmd, cap_be_n;
  wire [1:0]  mst_status;
  wire        ad_oe, cbe_oe, par_o, par_oe, frame_n_o, frame_oe, irdy_n_o, irdy_oe;
  wire        trdy_n_o, trdy_oe, stop_n_o, stop_oe, devsel_n_o, devsel_oe, req_n_o, req_oe;
  wire        inta_n_o, inta_oe, serr_oe, perr_n_o, perr_oe, mst_busy, mst_done;
  wire        tgt_req, tgt_wr, gnt_n, h_ctl, h_devsel, h_trdy, h_stop, h_ad_oe, h_par_oe, h_par;
  localparam [31:0] MADDR = 32'h2468ACE0, WDATA = 32'hA1B2C3D4, RDATA = 32'h8796A5B4;
  localparam [31:0] TRDATA = 32'h5A3C0F96;

  // Bus lines: whoever enables drives; controls pull up, undriven data flips each clock.
  wire [31:0] ad_w = ad_oe ? ad_o : h_ad_oe ? RDATA : t_adoe ? t_ad : ~ad_last;
  wire [3:0]  cbe_w = cbe_oe ? cbe_n_o : t_oe ? t_cbe : ~cbe_last;
  wire        par_w = par_oe ? par_o : h_par_oe ? h_par : t_paroe ? t_par : ~par_last;
  wire        frame_w = frame_oe ? frame_n_o : t_oe ? t_frame : 1'b1;
  wire        irdy_w = irdy_oe ? irdy_n_o : t_oe ? t_irdy : 1'b1;
  wire        trdy_w = trdy_oe ? trdy_n_o : h_ctl ? h_trdy : 1'b1;
  wire        stop_w = stop_oe ? stop_n_o : h_ctl ? h_stop : 1'b1;
  wire        devsel_w = devsel_oe ? devsel_n_o : h_ctl ? h_devsel : 1'b1;

  pcimt_top i_dut (.clk, .rst_b, .ad_i(ad_w), .ad_o, .ad_oe, .cbe_n_i(cbe_w), .cbe_n_o, .cbe_oe,
    .par_i(par_w), .par_o, .par_oe, .frame_n_i(frame_w), .frame_n_o, .frame_oe,
    .irdy_n_i(irdy_w), .irdy_n_o, .irdy_oe, .trdy_n_i(trdy_w), .trdy_n_o, .trdy_oe,
    .stop_n_i(stop_w), .stop_n_o, .stop_oe, .devsel_n_i(devsel_w), .devsel_n_o, .devsel_oe,
    .idsel_i(idsel), .req_n_o, .req_oe, .gnt_n_i(gnt_n), .inta_n_o, .inta_oe, .serr_oe,
    .perr_n_o, .perr_oe, .mst_start, .mst_cmd, .mst_addr(MADDR), .mst_wdata(WDATA),
    .mst_be_n(4'hA), .mst_busy, .mst_done, .mst_status, .mst_rdata,
    .tgt_mem_base(32'h40000000), .tgt_mem_mask(32'hFFFF0000), .tgt_io_base(32'h00001000),
    .tgt_io_mask(32'hFFFFFF00), .tgt_req, .tgt_cmd, .tgt_addr, .tgt_rdata(TRDATA), .tgt_wr,
    .tgt_wdata, .tgt_be_n, .irq);

  pcimt_host_model i_host (.clk, .rst_b, .mode(h_mode), .rdata(RDATA),
    .req_n(req_oe ? req_n_o : 1'b1), .frame_n(frame_w), .irdy_n(irdy_w), .ad(ad_w),
    .cbe_n(cbe_w), .gnt_n, .ctl_oe(h_ctl), .devsel_n(h_devsel), .trdy_n(h_trdy),
    .stop_n(h_stop), .ad_oe(h_ad_oe), .par_oe(h_par_oe), .par(h_par), .cap_addr,
    .cap_cmd, .cap_data, .cap_be_n);

  // Clock of 10 ns; line history and error pulse counters.
  initial forever #5 clk = ~clk;
  always @(posedge clk) begin
    ad_last <= ad_w;
    cbe_last <= cbe_w;
    par_last <= par_w;
    if (tgt_wr === 1'b1) wd_seen <= tgt_wdata;
    if (serr_oe === 1'b1) serr_cnt = serr_cnt + 1;
    if (perr_oe === 1'b1 && perr_n_o === 1'b0) perr_cnt = perr_cnt + 1;
  end

  task check(input [31:0] seen, input [31:0] exp, input string msg);
    begin
      checks = checks + 1;
      if (seen !== exp) begin
        failures = failures + 1;
        $display("unexpected at %0t: %s got %h want %h", $time, msg, seen, exp);
      end
    end
  endtask

  // Starts one initiator job of the block and waits for its completion pulse.
  task mst_job(input [3:0] c, input [1:0] m);
    integer n;
    begin
      @(posedge clk);
      h_mode <= m;
      mst_cmd <= c;
      mst_start <= 1'b1;
      @(posedge clk);
      mst_start <= 1'b0;
      n = 0;
      while (mst_done !== 1'b1 && n < 40) begin
        @(posedge clk);
        n = n + 1;
      end
      check(mst_done, 32'h1, "job done");
    end
  endtask

  // Acts as a foreign initiator of one data phase; bad flips address or data parity.
  task bus_xfer(input [3:0] c, input [31:0] a, input id, input [1:0] bad);
    integer n;
    begin
      @(posedge clk);
      t_oe <= 1'b1;
      t_frame <= 1'b0;
      t_adoe <= 1'b1;
      t_ad <= a;
      t_cbe <= c;
      idsel <= id;
      @(posedge clk);
      t_frame <= 1'b1;
      t_irdy <= 1'b0;
      t_cbe <= 4'h0;
      t_adoe <= c[0];
      t_ad <= WDATA;
      t_paroe <= 1'b1;
      t_par <= ^{a, c} ^ bad[0];
      idsel <= 1'b0;
      n = 0;
      got_claim = 1'b0;
      while (trdy_w !== 1'b0 && n < 8) begin
        @(posedge clk);
        n = n + 1;
        if (devsel_w === 1'b0) got_claim = 1'b1;
        if (n == 1) t_paroe <= c[0];
        if (n == 1) t_par <= ^{WDATA, 4'h0} ^ bad[1];
      end
      rdv = ad_w;
      t_irdy <= 1'b1;
      t_adoe <= 1'b0;
      @(posedge clk);
      t_oe <= 1'b0;
      t_paroe <= 1'b0;
      repeat (4) @(posedge clk);
    end
  endtask

  task test_master;
    begin
      mst_job(4'h7, 2'h0);
      check(mst_status, 32'h0, "write status");
      check(cap_addr, MADDR, "write address");
      check(cap_cmd, 32'h7, "write command");
      check(cap_data, WDATA, "write data");
      check(cap_be_n, 32'hA, "byte enables");
      mst_job(4'h6, 2'h0);
      check(mst_rdata, RDATA, "read data");
      mst_job(4'h6, 2'h2);
      check(mst_status, 32'h1, "retry status");
      check(perr_cnt, 32'h0, "false perr");
      mst_job(4'h7, 2'h1);
      check(mst_status, 32'h2, "abort status");
      $display("test master done");
    end
  endtask

  task test_target;
    begin
      bus_xfer(4'h3, 32'h00001003, 1'b0, 2'h0);
      check(got_claim, 32'h1, "io claim");
      check(tgt_addr, 32'h00001003, "io addr");
      check(wd_seen, WDATA, "io data");
      bus_xfer(4'h7, 32'h40000006, 1'b0, 2'h0);
      check(tgt_addr, 32'h40000004, "mem addr");
      check(tgt_be_n, 32'h0, "mem lanes");
      bus_xfer(4'hA, 32'h00000010, 1'b1, 2'h0);
      check(tgt_cmd, 32'hA, "cfg cmd");
      check(rdv, TRDATA, "cfg read data");
      bus_xfer(4'hA, 32'h00000020, 1'b0, 2'h0);
      check(got_claim, 32'h0, "cfg no select");
      $display("test target done");
    end
  endtask

  task test_parity;
    begin
      bus_xfer(4'h6, 32'h80000000, 1'b0, 2'h1);
      check(serr_cnt, 32'h1, "address parity");
      check(perr_cnt, 32'h0, "no claim no perr");
      bus_xfer(4'h7, 32'h40000010, 1'b0, 2'h2);
      check(perr_cnt, 32'h1, "data parity");
      check(serr_cnt, 32'h1, "serr count");
      $display("test parity done");
    end
  endtask

  task test_irq;
    begin
      @(posedge clk);
      irq <= 1'b1;
      repeat (2) @(posedge clk);
      check({inta_oe, inta_n_o}, 32'h2, "irq on");
      irq <= 1'b0;
      repeat (2) @(posedge clk);
      check(inta_oe, 32'h0, "irq off");
      $display("test irq done");
    end
  endtask

  task test_done;
    begin
      $display("checks %0d failures %0d", checks, failures);
      if (failures == 0 && checks > 0)
        $display("Run complete: PASS");
      else
        $display("Run complete: FAIL");
      $finish;
    end
  endtask

  // Main sequence: reset for two clocks, then every scenario in turn.
  initial begin
    rst_b <= 1'b0;
    @(posedge clk);
    check({ad_oe,cbe_oe,frame_oe,irdy_oe,trdy_oe,devsel_oe,req_oe}, 32'h0, "reset");
    @(posedge clk);
    rst_b <= 1'b1;
    test_master;
    test_target;
    test_parity;
    test_irq;
    test_done;
  end

  // Watchdog well past the expected run length.
  initial begin
    repeat (5000) @(posedge clk);
    failures = failures + 1;
    test_done;
  end
endmodule // tb
